// File: include/adcs_pkg.sv
package adcs_pkg;
  // ----------------------------------------
  // data path
  // ----------------------------------------
  localparam int RES_W = 10;
  localparam int NSLOT = 8;
  localparam int CFG_W = 23;
  localparam int NSRC  = 4;

  // ----------------------------------------
  // register map, one window per host
  // ----------------------------------------
  localparam int         HOST_BIT = 5;
  localparam logic [1:0] WIN_HI   = 2'h0;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_THR  = 5'h04;
  localparam logic [4:0] OFF_RESA = 5'h08;
  localparam logic [4:0] OFF_RESB = 5'h0c;
  localparam logic [4:0] OFF_STAT = 5'h10;

  // control word fields
  localparam int F_START  = 0;
  localparam int F_TRG_EN = 1;
  localparam int F_TRG_IG = 2;
  localparam int F_SINGLE = 3;
  localparam int F_CHAN   = 4;
  localparam int F_GROUP  = 7;
  localparam int F_DLY    = 8;
  localparam int F_EACH   = 12;
  localparam int F_PLS_EN = 13;
  localparam int F_PLS_8  = 14;
  localparam int F_CH7_ID = 15;
  localparam int F_TOUCH  = 16;
  localparam int F_RDPTR  = 18;
  localparam int F_ALT    = 23;

  // status fields
  localparam int S_DONE = 0;
  localparam int S_PEN  = 1;
  localparam int S_BUSY = 2;
  localparam int S_THR  = 3;

  // reset values
  localparam logic [CFG_W-1:0] CFG_RST = 23'h000000;
  localparam logic [RES_W-1:0] THR_RST = 10'h3ff;

  // ----------------------------------------
  // sequencing constants
  // ----------------------------------------
  localparam logic [1:0] TS_OFF  = 2'h0;
  localparam logic [1:0] TS_PEN  = 2'h1;
  localparam logic [1:0] TS_RES  = 2'h2;
  localparam logic [1:0] TS_POS  = 2'h3;
  localparam logic [1:0] MEAS_X  = 2'h0;
  localparam logic [1:0] MEAS_Y  = 2'h1;
  localparam logic [1:0] MEAS_C  = 2'h2;
  localparam logic [2:0] SLOT_Y0 = 3'h3;
  localparam logic [2:0] SLOT_C0 = 3'h6;
  localparam logic [2:0] SLOT_LAST = 3'h7;
  localparam logic [3:0] CH_TOUCH_X_PLATE_A = 4'hc;
  localparam logic [3:0] CH_TOUCH_Y_PLATE_A = 4'he;
  localparam logic [3:0] PLS_SHORT = 4'h4;
  localparam logic [3:0] PLS_LONG  = 4'h8;
  localparam logic [3:0] DLY_MAX   = 4'h8;

  // timing: delay step of 1 ms at 40 MHz
  localparam int CLK_HZ      = 40_000_000;
  localparam int DLY_STEP_US = 1000;
  localparam int CYC_PER_MS  = CLK_HZ / 1_000_000 * DLY_STEP_US;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_START = 2'b10,
    ST_WAIT  = 2'b11
  } adcs_state_t;
endpackage

// File: include/adcs_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
// delay timer handshake between sequencer and timer
interface adcs_tmr_if;
  logic       load;
  logic [3:0] ms;
  logic       done;
  modport ctl (output load, output ms, input done);
  modport tmr (input load, input ms, output done);
endinterface
`default_nettype wire

// File: tb/adc_sequencer_touch_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_touch_control_tb;
  import adcs_pkg::*;
  // ----------------------------------------
  // signals and bookkeeping
  // ----------------------------------------
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        trg = 1'b0, pen = 1'b0, slow = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, sar_start, sar_done, pulse, bias, tsel;
  logic [3:0]  sar_channel;
  logic [9:0]  sar_result;
  logic [1:0]  tmode, tmeas, host_irq;
  logic [32:0] rq[$];
  logic [6:0]  cq[$];
  logic [6:0]  ce;
  logic [9:0]  res[8];
  int          num_errors = 0, n_tests = 0, ncv = 0, pcnt = 0, c, dc;
  time         t0, t1, t2;
  // 40 MHz clock
  always #12.5 pclk = ~pclk;
  // short ms count keeps delay runs brief
  adcs_seq #(.CYC_PER_MS_P(20)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_conversion_trigger(trg), .pen_contact(pen), .sar_start(sar_start),
    .sar_channel(sar_channel), .sar_done(sar_done), .sar_result(sar_result),
    .conversion_pulse_output(pulse), .thermistor_bias_en(bias), .temp_or_id_select(tsel),
    .touch_mode_out(tmode), .touch_meas_sel(tmeas), .host_irq(host_irq));
  adcs_core_model core (.pclk(pclk), .presetn(presetn), .sar_start(sar_start),
    .sar_channel(sar_channel), .slow(slow), .sar_done(sar_done), .sar_result(sar_result));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] ad(input logic h, input logic [4:0] off);
    return {WIN_HI, h, off};
  endfunction
  task automatic check(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one transfer; request held until pready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && i++ < 50);
    if (pready !== 1'b1) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // expected conversion: care flag, meas select, channel
  task automatic conv(input logic [3:0] ch, input logic [2:0] m);
    cq.push_back({m, ch});
    res[ncv % 8] = {ch, 6'(ncv)};
    ncv++;
  endtask
  task automatic ser(input logic [3:0] base, input logic step);
    for (int i = 0; i < 8; i++) conv(base + (step ? 4'(i) : 4'h0), 3'h0);
  endtask
  // wait for a host's completion, check status, then clear it
  task automatic fin(input logic h, input logic [32:0] st);
    for (int i = 0; i < 20000 && host_irq[h] !== 1'b1; i++) @(posedge pclk);
    check("irq", 33'(2'b01 << h), 33'(host_irq));
    rd(ad(h, OFF_STAT), st);
    wr(ad(h, OFF_STAT), 32'hf);
  endtask
  task automatic trig();
    repeat (4) @(posedge pclk);
    trg <= 1'b1;
    repeat (4) @(posedge pclk);
    trg <= 1'b0;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // monitors: read data and conversion starts
  // ----------------------------------------
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite) check("rdata", rq.pop_front(), {pslverr, prdata});
  // every start must match the oldest expected conversion
  always @(posedge pclk)
    if (sar_start === 1'b1) begin
      if (cq.size() == 0) check("start", 33'h0, 33'h1);
      else begin
        ce = cq.pop_front();
        check("chan", 33'(ce[3:0]), 33'(sar_channel));
        if (ce[6]) check("meas", 33'(ce[5:4]), 33'(tmeas));
        check("bias", 33'h1, 33'(bias));
      end
      if (pulse) pcnt++;
      if (t1 == 0) t1 = $time;
      t2 = $time;
    end
  // watchdog cuts a hang short
  initial begin
    #1_000_000;
    num_errors++;
    summarize();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    c = $urandom(32'h65feafa2);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(ad(0, OFF_CTRL), 33'h0);
    rd(ad(1, OFF_THR), 33'(THR_RST));
    rd(8'h14, {1'b1, 32'h0});
    $display("test reset done");
    ser(4'h0, 1'b1);
    wr(ad(0, OFF_CTRL), 32'h1);
    fin(1'b0, 33'h1);
    for (int p = 0; p < 4; p++) begin
      wr(ad(0, OFF_CTRL), p << F_RDPTR);
      rd(ad(0, OFF_RESA), {13'h0, res[2*p+1], res[2*p]});
      rd(ad(0, OFF_RESB), {13'h0, res[(2*p+3)%8], res[(2*p+2)%8]});
    end
    $display("test group series done");
    slow <= 1'b1;
    c = $urandom_range(15, 0);
    ser(4'(c), 1'b0);
    wr(ad(1, OFF_THR), 32'h0);
    wr(ad(1, OFF_CTRL), 32'ha | (c % 8) << F_CHAN | (c / 8) << F_GROUP);
    trig();
    fin(1'b1, 33'h9);
    wr(ad(1, OFF_THR), 32'h3ff);
    wr(ad(1, OFF_CTRL), 32'h6);
    trig();
    repeat (60) @(posedge pclk);
    rd(ad(1, OFF_STAT), 33'h0);
    $display("test trigger done");
    ser(4'h8, 1'b1);
    ser(4'h5, 1'b0);
    wr(ad(0, OFF_CTRL), 32'h2000);
    wr(ad(0, OFF_CTRL), 32'h800081);
    wr(ad(1, OFF_CTRL), 32'h59);
    rd(ad(0, OFF_CTRL), 33'h2000);
    fin(1'b0, 33'h5);
    fin(1'b1, 33'h1);
    $display("test queue done");
    for (int k = 0; k < 2; k++) begin
      pcnt = 0;
      t1 = 0;
      ser(4'h0, 1'b1);
      wr(ad(0, OFF_CTRL), 32'h1 | 2 << F_DLY | 1 << F_PLS_EN | k << F_PLS_8 |
                          k << F_CH7_ID | k << F_EACH);
      t0 = $time;
      fin(1'b0, 33'h1);
      dc = int'((t1 - t0) / 25);
      check("delay", 33'h1, 33'(dc >= 41 && dc <= 50));
      check("pulse", k ? 33'h8 : 33'h4, 33'(pcnt));
      check("gap", 33'(k), 33'((t2 - t1) / 25 > 280));
      check("tsel", 33'(k), 33'(tsel));
    end
    $display("test delay and pulse done");
    for (int m = 2; m < 4; m++) begin
      for (int i = 0; i < 8; i++)
        conv(i > 5 ? CH_TOUCH_X_PLATE_A : ((i < 3) == (m == 2) ? CH_TOUCH_X_PLATE_A : CH_TOUCH_Y_PLATE_A),
             {1'b1, i < 3 ? MEAS_X : (i < 6 ? MEAS_Y : MEAS_C)});
      wr(ad(0, OFF_CTRL), 32'h1 | m << F_TOUCH);
      fin(1'b0, 33'h1);
    end
    $display("test touch series done");
    wr(ad(0, OFF_CTRL), 32'h1 << F_TOUCH);
    pen <= 1'b1;
    repeat (2) @(posedge pclk);
    check("tmode", 33'(TS_PEN), 33'(tmode));
    fin(1'b0, 33'h2);
    pen <= 1'b0;
    $display("test pen done");
    summarize();
  end
endmodule  // adc_sequencer_touch_control_tb
`default_nettype wire

// File: tb/adcs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// converter core stand-in
// ----------------------------------------
module adcs_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sar_start,
  input  wire logic [3:0] sar_channel,
  input  wire logic       slow,
  output var  logic       sar_done,
  output var  logic [9:0] sar_result
);
  int         wt = 0;
  logic [5:0] n = 6'h00;
  logic [3:0] ch = 4'h0;
  // result carries channel and running count; bus toggles while invalid
  always @(posedge pclk) begin
    sar_done <= 1'b0;
    sar_result <= ~sar_result;
    if (!presetn) begin
      wt = 0;
      n = 6'h00;
      sar_result <= 10'h2aa;
    end else if (wt > 1) begin
      wt--;
    end else if (wt == 1) begin
      wt = 0;
      sar_done <= 1'b1;
      sar_result <= {ch, n};
      n++;
    end else if (sar_start) begin
      ch = sar_channel;
      wt = slow ? $urandom_range(6, 1) : 1;  // slow mode stretches the answer
    end
  end
endmodule  // adcs_core_model
`default_nettype wire

// File: verilog/adcs_delay.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_delay
  import adcs_pkg::*;
#(
  parameter int unsigned CYC = CYC_PER_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  adcs_tmr_if.tmr  t
);
  localparam int CW = $clog2(CYC);

  logic [3:0]    ms_reg;
  logic [CW-1:0] cyc_reg;

  // ----------------------------------------
  // millisecond down counter
  // ----------------------------------------
  // requests above the top step are clamped
  wire logic [3:0] ms_clip = (t.ms > DLY_MAX) ? DLY_MAX : t.ms;
  wire logic       cyc_end = (cyc_reg == '0);

  // load restarts the wait from scratch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_reg  <= 4'h0;
      cyc_reg <= '0;
    end else if (t.load) begin
      ms_reg  <= ms_clip;
      cyc_reg <= CW'(CYC - 1);
    end else if (ms_reg != 4'h0) begin
      ms_reg  <= cyc_end ? ms_reg - 4'h1 : ms_reg;
      cyc_reg <= cyc_end ? CW'(CYC - 1) : cyc_reg - 1'b1;
    end
  end

  // a load in flight is never reported as done
  assign t.done = (ms_reg == 4'h0) & ~t.load;
endmodule // adcs_delay
`default_nettype wire

// File: verilog/adcs_seq.sv
// Contract
// - one shared core, 10-bit result each
// - group bit picks channels 0-7 or 8-15
// - start by trigger rising edge or command
// - eight group channels or eight on one
// - compare results against preset threshold
// - 0-8 ms delay, optionally between conversions
// - ignore bit blocks every trigger pin edge
// - completion interrupt only to requesting host
// - arbitrate both hosts, one series at once
// - eight results held in one bank
// - pulse output spans 4 or 8 conversions
// - thermistor bias only during conversions
// - channel 7 picks temperature or id voltage
// - pen detect without core, interrupts host
// - resistive and position modes, contact too
// - slots X 0-2, Y 3-5, contact 6-7
// - each read returns two 10-bit results
// - bit 23 set writes queued alternate set
// - bit 23 reads 0, alternate unreadable
// - two separate result registers
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module adcs_seq
  import adcs_pkg::*;
#(
  parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  input  wire logic             external_conversion_trigger,
  input  wire logic             pen_contact,
  output var  logic             sar_start,
  output var  logic [3:0]       sar_channel,
  input  wire logic             sar_done,
  input  wire logic [RES_W-1:0] sar_result,
  output var  logic             conversion_pulse_output,
  output var  logic             thermistor_bias_en,
  output var  logic             temp_or_id_select,
  output var  logic [1:0]       touch_mode_out,
  output var  logic [1:0]       touch_meas_sel,
  output var  logic [1:0]       host_irq
);
  adcs_tmr_if tif ();

  adcs_delay #(.CYC(CYC_PER_MS_P)) u_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (tif.tmr)
  );

  logic [CFG_W-1:0] cfg_reg [NSRC];
  logic [RES_W-1:0] thr_reg [2];
  logic [RES_W-1:0] slot_mem [NSLOT];
  logic [NSRC-1:0]  age_reg [NSRC];
  logic [NSRC-1:0]  pend_reg;
  logic [1:0]       done_reg;
  logic [1:0]       pen_reg;
  logic [1:0]       thr_hit_reg;
  logic [CFG_W-1:0] act_cfg_reg;
  logic [1:0]       act_src_reg;
  logic [2:0]       slot_reg;
  logic [2:0]       slot_next;
  adcs_state_t      state_reg;
  adcs_state_t      state_next;
  logic             trig_meta_reg;
  logic             trig_sync_reg;
  logic             trig_prev_reg;
  logic             pen_meta_reg;
  logic             pen_sync_reg;
  logic             pen_prev_reg;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // both pins come from outside the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
      pen_meta_reg  <= 1'b0;
      pen_sync_reg  <= 1'b0;
      pen_prev_reg  <= 1'b0;
    end else begin
      trig_meta_reg <= external_conversion_trigger;
      trig_sync_reg <= trig_meta_reg;
      trig_prev_reg <= trig_sync_reg;
      pen_meta_reg  <= pen_contact;
      pen_sync_reg  <= pen_meta_reg;
      pen_prev_reg  <= pen_sync_reg;
    end
  end

  wire logic trig_edge = trig_sync_reg & ~trig_prev_reg;
  wire logic pen_edge  = pen_sync_reg & ~pen_prev_reg;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire logic       setup    = psel & ~penable;
  wire logic       wr       = psel & penable & pready & pwrite;
  wire logic       win_host = paddr[HOST_BIT];
  wire logic [4:0] off      = paddr[4:0];
  wire logic       in_win   = (paddr[7:6] == WIN_HI);
  wire logic       wr_ctrl  = wr & in_win & (off == OFF_CTRL);
  wire logic       wr_thr   = wr & in_win & (off == OFF_THR);
  wire logic       wr_stat  = wr & in_win & (off == OFF_STAT);
  wire logic [1:0] wr_src   = {win_host, pwdata[F_ALT]};
  wire logic [1:0] own_src  = {win_host, 1'b0};
  wire logic       busy     = (state_reg != ST_IDLE);

  // result pairs, read pointer picks the first pair
  wire logic [1:0] ptr_a = cfg_reg[own_src][F_RDPTR +: 2];
  wire logic [1:0] ptr_b = ptr_a + 2'h1;
  wire logic [31:0] res_a = {12'h000, slot_mem[{ptr_a, 1'b1}],
                             slot_mem[{ptr_a, 1'b0}]};
  wire logic [31:0] res_b = {12'h000, slot_mem[{ptr_b, 1'b1}],
                             slot_mem[{ptr_b, 1'b0}]};
  // control read shows own set only, select bit forced low
  wire logic [31:0] rd_ctrl = {9'h000, cfg_reg[own_src]};
  wire logic [31:0] rd_stat = {28'h0000000, thr_hit_reg[win_host], busy,
                               pen_reg[win_host], done_reg[win_host]};
  wire logic [31:0] rd_thr  = {22'h000000, thr_reg[win_host]};
  wire logic        rd_hit  = in_win & ((off == OFF_CTRL) | (off == OFF_THR) |
                              (off == OFF_RESA) | (off == OFF_RESB) |
                              (off == OFF_STAT));
  wire logic [31:0] rd_data =
    (off == OFF_CTRL) ? rd_ctrl :
    (off == OFF_THR)  ? rd_thr  :
    (off == OFF_RESA) ? res_a   :
    (off == OFF_RESB) ? res_b   :
    (off == OFF_STAT) ? rd_stat : 32'h00000000;

  // zero wait: answer in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= (setup & ~pwrite & rd_hit) ? rd_data : 32'h00000000;
      pready  <= setup;
      pslverr <= setup & ~rd_hit;
    end
  end

  // ----------------------------------------
  // control sets and thresholds
  // ----------------------------------------
  // start bit is a command, never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NSRC; i++) cfg_reg[i] <= CFG_RST;
      thr_reg[0] <= THR_RST;
      thr_reg[1] <= THR_RST;
    end else begin
      if (wr_ctrl) cfg_reg[wr_src] <= {pwdata[CFG_W-1:1], 1'b0};
      if (wr_thr) thr_reg[win_host] <= pwdata[RES_W-1:0];
    end
  end

  // ----------------------------------------
  // request queue in arrival order
  // ----------------------------------------
  logic [NSRC-1:0] req_vec;
  logic [NSRC-1:0] new_vec;
  logic [NSRC-1:0] grant;
  logic [1:0]      pick;
  logic [NSRC-1:0] pop_vec;
  wire logic       pop = (state_reg == ST_IDLE) & (|pend_reg);

  // age_reg[i][j] set: source j waits longer than i
  for (genvar i = 0; i < NSRC; i++) begin : g_src
    assign req_vec[i] = (wr_ctrl & pwdata[F_START] & (wr_src == 2'(i))) |
                        ((i % 2 == 0) & trig_edge & cfg_reg[i][F_TRG_EN] &
                         ~cfg_reg[i][F_TRG_IG]);
    assign new_vec[i] = req_vec[i] & ~pend_reg[i];
    assign grant[i]   = pend_reg[i] & ~(|(age_reg[i] & pend_reg));

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        age_reg[i] <= '0;
      end else begin
        for (int j = 0; j < NSRC; j++) begin
          if (new_vec[i]) age_reg[i][j] <= pend_reg[j] | (new_vec[j] & (j < i));
          else if (new_vec[j]) age_reg[i][j] <= 1'b0;
        end
      end
    end
  end

  // same-cycle ties go to the lower source index
  assign pick    = grant[0] ? 2'h0 : grant[1] ? 2'h1 : grant[2] ? 2'h2 : 2'h3;
  assign pop_vec = pop ? (4'h1 << pick) : 4'h0;

  // a request for a source already waiting merges with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pend_reg <= '0;
    else pend_reg <= (pend_reg | new_vec) & ~pop_vec;
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  wire logic conv_ok = (state_reg == ST_WAIT) & sar_done;
  wire logic last    = (slot_reg == SLOT_LAST);
  wire logic fin     = conv_ok & last;
  wire logic each    = act_cfg_reg[F_EACH];

  // delay runs before the first and, if asked, every conversion
  assign tif.load = pop | (conv_ok & ~last & each);
  assign tif.ms   = pop ? cfg_reg[pick][F_DLY +: 4] : act_cfg_reg[F_DLY +: 4];

  // one conversion at a time on the shared core
  always_comb begin
    state_next = state_reg;
    slot_next  = slot_reg;
    case (state_reg)
      ST_IDLE: begin
        if (pop) begin
          state_next = ST_DELAY;
          slot_next  = 3'h0;
        end
      end
      ST_DELAY: begin
        if (tif.done) state_next = ST_START;
      end
      ST_START: state_next = ST_WAIT;
      ST_WAIT: begin
        if (sar_done) begin
          state_next = last ? ST_IDLE : (each ? ST_DELAY : ST_START);
          slot_next  = last ? slot_reg : slot_reg + 3'h1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // channel choice from the slot about to run
  wire logic [1:0] ts_mode = act_cfg_reg[F_TOUCH +: 2];
  wire logic       is_ts   = (ts_mode == TS_RES) | (ts_mode == TS_POS);
  wire logic [1:0] meas    = (slot_next < SLOT_Y0) ? MEAS_X :
                             (slot_next < SLOT_C0) ? MEAS_Y : MEAS_C;
  // position reads each axis through the opposite plate
  wire logic [3:0] ts_ch   = (meas == MEAS_C) ? CH_TOUCH_X_PLATE_A :
                             ((meas == MEAS_X) == (ts_mode == TS_RES)) ?
                             CH_TOUCH_X_PLATE_A : CH_TOUCH_Y_PLATE_A;
  wire logic [2:0] in_grp  = act_cfg_reg[F_SINGLE] ? act_cfg_reg[F_CHAN +: 3]
                             : slot_next;
  wire logic [3:0] sel_ch  = is_ts ? ts_ch
                             : {act_cfg_reg[F_GROUP], in_grp};
  wire logic [3:0] pls_len = act_cfg_reg[F_PLS_8] ? PLS_LONG : PLS_SHORT;
  wire logic       in_conv = (state_next == ST_START) |
                             (state_next == ST_WAIT);
  wire logic       in_ser  = in_conv |
                             ((state_next == ST_DELAY) & (slot_next != 3'h0));

  // sequencer state, active set latched at pop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= ST_IDLE;
      slot_reg    <= 3'h0;
      act_src_reg <= 2'h0;
      act_cfg_reg <= CFG_RST;
    end else begin
      state_reg <= state_next;
      slot_reg  <= slot_next;
      if (pop) begin
        act_src_reg <= pick;
        act_cfg_reg <= cfg_reg[pick];
      end
    end
  end

  // one bank of eight, shared by every series
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NSLOT; i++) slot_mem[i] <= '0;
    end else if (conv_ok) begin
      slot_mem[slot_reg] <= sar_result;
    end
  end

  // ----------------------------------------
  // per host status and interrupt
  // ----------------------------------------
  logic [1:0] done_next;
  logic [1:0] pen_next;
  logic [1:0] thr_hit_next;

  // a set event beats a clear in the same cycle
  for (genvar h = 0; h < 2; h++) begin : g_host
    wire logic clr  = wr_stat & (win_host == 1'(h));
    wire logic mine = (act_src_reg[1] == 1'(h));
    wire logic pen_ev = pen_edge & ~busy &
                        (cfg_reg[2*h][F_TOUCH +: 2] == TS_PEN);
    wire logic thr_ev = conv_ok & mine & (sar_result > thr_reg[h]);

    assign done_next[h] = (fin & mine) |
                          (done_reg[h] & ~(clr & pwdata[S_DONE]));
    assign pen_next[h] = pen_ev | (pen_reg[h] & ~(clr & pwdata[S_PEN]));
    assign thr_hit_next[h] = thr_ev | (thr_hit_reg[h] & ~(clr & pwdata[S_THR]));
  end

  // one process owns every status bit of both hosts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg    <= 2'h0;
      pen_reg     <= 2'h0;
      thr_hit_reg <= 2'h0;
      host_irq    <= 2'h0;
    end else begin
      done_reg    <= done_next;
      pen_reg     <= pen_next;
      thr_hit_reg <= thr_hit_next;
      host_irq    <= done_reg | pen_reg;
    end
  end

  // ----------------------------------------
  // core and analog side controls
  // ----------------------------------------
  // pen detect bias is shown while the core is free and a host's primary set selects pen mode, or while the active set's touch mode is pen
  wire logic pen_arm = (cfg_reg[0][F_TOUCH +: 2] == TS_PEN) |
                       (cfg_reg[2][F_TOUCH +: 2] == TS_PEN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_start               <= 1'b0;
      sar_channel             <= 4'h0;
      conversion_pulse_output <= 1'b0;
      thermistor_bias_en      <= 1'b0;
      temp_or_id_select       <= 1'b0;
      touch_mode_out          <= TS_OFF;
      touch_meas_sel          <= MEAS_X;
    end else begin
      sar_start <= (state_next == ST_START);
      if (state_next == ST_START) sar_channel <= sel_ch;
      conversion_pulse_output <= act_cfg_reg[F_PLS_EN] & in_ser &
                                 ({1'b0, slot_next} < pls_len);
      thermistor_bias_en <= in_conv;
      temp_or_id_select  <= busy ? act_cfg_reg[F_CH7_ID]
                                 : cfg_reg[0][F_CH7_ID];
      touch_mode_out <= busy ? ts_mode : (pen_arm ? TS_PEN : TS_OFF);
      touch_meas_sel <= meas;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_single: assert property (
    sar_start |=> !sar_start ##0 state_reg == ST_WAIT)
    else $error("start pulse longer than one cycle");
  a_group_chan: assert property (
    (sar_start && !is_ts) |-> sar_channel[3] == act_cfg_reg[F_GROUP])
    else $error("channel outside selected group");
  a_trig_ignore: assert property (
    (trig_edge && !wr_ctrl) |-> !(req_vec[0] && cfg_reg[0][F_TRG_IG]) &&
                                !(req_vec[2] && cfg_reg[2][F_TRG_IG]))
    else $error("ignored trigger started a series");
  a_bias_window: assert property (
    thermistor_bias_en |-> (state_reg == ST_START || state_reg == ST_WAIT))
    else $error("thermistor bias outside conversion");
  a_alt_bit_zero: assert property (
    (psel && penable && !pwrite && pready && in_win && off == OFF_CTRL)
    |-> !prdata[F_ALT])
    else $error("alternate select bit read as one");
  a_irq_owner: assert property (
    (fin && !act_src_reg[1] && !done_reg[1] && !pen_reg[1])
    |-> ##2 host_irq[0] && !host_irq[1])
    else $error("completion interrupt to wrong host");
  a_slot_step: assert property (
    (conv_ok && !last) |=> slot_reg == $past(slot_reg) + 3'h1)
    else $error("slot did not advance");
  a_delay_hold: assert property (
    (state_reg == ST_DELAY && !tif.done) |=> !sar_start)
    else $error("conversion started before delay ended");
  a_pulse_short: assert property (
    (busy && slot_reg >= 3'h4 && !act_cfg_reg[F_PLS_8]) |-> !conversion_pulse_output)
    else $error("pulse longer than four conversions");
  a_pop_order: assert property (
    pop |=> state_reg == ST_DELAY && !pend_reg[$past(pick)])
    else $error("pending request not taken");
endmodule // adcs_seq
`default_nettype wire
